// File: mfr_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock; flush empties it in one cycle
// Notes:   Read data is the head entry, valid while not empty
`default_nettype none

module mfr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready_o  = (count_q != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage write
  always_ff @(posedge core_clk_i) begin
    if (ce_i && push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (ce_i) begin
      if (flush_i) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q  <= '0;
      end else begin
        if (push) begin
          wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
        end
        if (pop) begin
          rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
        end
        if (push && !pop) begin
          count_q <= count_q + (PW+1)'(1);
        end else if (pop && !push) begin
          count_q <= count_q - (PW+1)'(1);
        end
      end
    end
  end

endmodule : mfr_fifo // mfr_fifo

`default_nettype wire

// File: mfr_host_model.sv
// Purpose: Host controller side of the flash link
// Assumes: One link clock is 8 core cycles, mode 0 framing
// Notes:   Released lines are resolved by the bench
`default_nettype none

module mfr_host_model (
  input  wire logic       core_clk_i,
  input  wire logic [3:0] io_i,
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic      [3:0] drv_o,
  output logic      [3:0] en_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle link, clock parked low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    drv_o  = 4'h0;
    en_o   = 4'h0;
  end

  // Step n core cycles, landing just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  // Select or deselect; clock stands still outside frames
  task automatic sel(input logic s);
    cyc(4);
    cs_n_o = s;
    cyc(4);
    sclk_o = 1'b0;
  endtask

  // One link clock: drive at the fall, sample just before the rise
  task automatic clk1(input logic [3:0] d, e, input bit rel, output logic [3:0] q);
    sclk_o = 1'b0;
    drv_o  = d;
    en_o   = e;
    cyc(4);
    q      = io_i;
    sclk_o = 1'b1;
    cyc(3);
    if (rel) en_o = 4'h0;
    cyc(1);
  endtask

  // Send nb bits over w lanes, MSB first, higher bit on higher lane
  task automatic shift(input logic [23:0] v, input int nb, w, input bit rel);
    logic [3:0] d;
    logic [3:0] q;
    int         k;
    k = nb - 1;
    for (int c = 0; c < nb / w; c++) begin
      d = 4'h0;
      for (int j = w - 1; j >= 0; j--) begin
        d[j] = v[k];
        k--;
      end
      clk1(d, 4'((1 << w) - 1), rel && (c == nb / w - 1), q);
    end
  endtask

  // Collect one byte from w lanes
  task automatic rxb(input int w, output logic [7:0] b);
    logic [3:0] q;
    for (int c = 0; c < 8 / w; c++) begin
      clk1(4'h0, 4'h0, 1'b0, q);
      b = (b << w) | 8'(q & 4'((1 << w) - 1));
    end
  endtask

endmodule // mfr_host_model

`default_nettype wire

// File: mfr_mem.sv
// Purpose: Byte array standing for the flash contents
// Assumes: Loaded through the write port; one-cycle registered read
// Notes:   Size is a parameter; upper address bits are ignored by the caller
`default_nettype none

module mfr_mem #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 8
) (
  input  wire logic          core_clk_i,
  input  wire logic          ce_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i,
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_data_q;

  // Preload port
  always_ff @(posedge core_clk_i) begin
    if (ce_i && wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read
  always_ff @(posedge core_clk_i) begin
    if (ce_i && rd_en_i) begin
      rd_data_q <= mem_q[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_q;

endmodule : mfr_mem // mfr_mem

`default_nettype wire

// File: mfr_pkg.sv
// Purpose: Shared constants and types for the multi-line flash read front end
// Assumes: One core clock; link pins sampled, never used as a clock
// Notes:   Wrap bits are held as {length[1:0], disable}
`default_nettype none

package mfr_pkg;

  // Opcodes understood by the front end
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;

  // Address and byte geometry
  localparam int unsigned ADDR_BITS  = 24;
  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned LANES_DUAL = 2;
  localparam int unsigned LANES_QUAD = 4;

  // Link clocks per phase
  localparam logic [4:0] OPC_CLKS_SPI  = 5'h08;
  localparam logic [4:0] OPC_CLKS_QPI  = 5'h02;
  localparam logic [4:0] ADDR_CLKS_DUAL = 5'h0c;
  localparam logic [4:0] ADDR_CLKS_QUAD = 5'h06;
  localparam logic [4:0] MODE_CLKS_DUAL = 5'h04;
  localparam logic [4:0] MODE_CLKS_QUAD = 5'h02;
  localparam logic [4:0] DUMMY_CLKS_SPI_QUAD = 5'h04;
  localparam logic [4:0] DUMMY_CLKS_DUAL     = 5'h00;

  // Mode byte field that keeps the next cycle opcode-less
  localparam int unsigned  MODE_SEL_MSB = 5;
  localparam int unsigned  MODE_SEL_LSB = 4;
  localparam logic [1:0]   MODE_SEL_CONT = 2'h2;

  // Wrap section base length
  localparam logic [7:0] WRAP_BASE_LEN = 8'h08;

  // Reset values
  localparam logic [1:0] RST_WRAP_LEN   = 2'h0;
  localparam logic       RST_WRAP_DIS   = 1'b1;
  localparam logic [1:0] RST_READ_PARAM = 2'h0;

  // Data buffer
  localparam int unsigned FIFO_DEPTH = 8;

  // Sampled link pins
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } mfr_pins_t;

  // Wrap setting bits
  typedef struct packed {
    logic [1:0] len;
    logic       dis;
  } mfr_wrap_t;

  // Command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } mfr_state_t;

endpackage : mfr_pkg

`default_nettype wire

// File: mfr_read_front_end.sv
// Purpose: Dual and quad address-and-data read front end of a serial flash
// Assumes: Link pins are asynchronous and sampled by core_clk_i (at least 8x sclk)
// Notes:   Inputs sampled on sclk rise, outputs changed on sclk fall
`default_nettype none

module mfr_read_front_end #(
  parameter int unsigned MEM_AW     = 12,
  parameter int unsigned FIFO_DEPTH = mfr_pkg::FIFO_DEPTH
) (
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  // Link pins
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic [3:0]        io_i,
  output logic      [3:0]        io_o,
  output logic      [3:0]        io_oe_o,
  // Configuration
  input  wire logic              quad_enable_bit_i,
  input  wire logic              four_wire_command_mode_i,
  input  wire logic              wrap_set_i,
  input  wire logic [2:0]        wrap_setting_bits_i,
  input  wire logic              read_param_set_i,
  input  wire logic [1:0]        read_dummy_sel_i,
  // Array preload
  input  wire logic              mem_wr_en_i,
  input  wire logic [MEM_AW-1:0] mem_wr_addr_i,
  input  wire logic [7:0]        mem_wr_data_i,
  // Status
  output logic                   continuous_mode_o,
  output logic                   cmd_reject_o,
  output logic                   busy_o
);

  mfr_pkg::mfr_pins_t  sync1_q;
  mfr_pkg::mfr_pins_t  sync2_q;
  logic                sclk_prev_q;
  logic                cs_prev_q;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_fall;
  logic                cs_high;

  mfr_pkg::mfr_state_t state_q;
  logic [4:0]          cnt_q;
  logic [7:0]          opcode_q;
  logic [23:0]         addr_q;
  logic [7:0]          mode_q;
  logic                quad_q;
  logic                qpi_q;
  logic                wrap_go_q;
  logic                cont_q;
  logic                cont_quad_q;
  logic [7:0]          opc_next;
  logic [23:0]         addr_next;
  logic [7:0]          mode_next;
  logic [4:0]          phase_last;
  logic [4:0]          dummy_clks;

  mfr_pkg::mfr_wrap_t  wrap_q;
  logic [1:0]          read_param_q;

  logic                fetch_en_q;
  logic                pend_q;
  logic [23:0]         fetch_addr_q;
  logic [7:0]          wrap_mask;
  logic [MEM_AW-1:0]   mem_rd_addr;
  logic [7:0]          mem_rd_data;
  logic                mem_rd_en;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [7:0]          fifo_out_data;
  logic                fifo_pop;
  logic                fifo_flush;

  logic [1:0]          beat_q;
  logic [7:0]          shift_q;
  logic [3:0]          io_q;
  logic [3:0]          io_oe_q;
  logic                reject_q;
  logic [7:0]          out_byte;

  // Two-flop synchronisers on every link pin
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      sync2_q <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
    end else if (ce_i) begin
      sync1_q <= '{cs_n: cs_n_i, sclk: sclk_i, io: io_i};
      sync2_q <= sync1_q;
    end
  end

  // Edge history of the synchronised pins
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else if (ce_i) begin
      sclk_prev_q <= sync2_q.sclk;
      cs_prev_q   <= sync2_q.cs_n;
    end
  end

  assign cs_high   = sync2_q.cs_n;
  assign cs_fall   = cs_prev_q & ~sync2_q.cs_n;
  assign sclk_rise = ~cs_high & sync2_q.sclk & ~sclk_prev_q;
  assign sclk_fall = ~cs_high & ~sync2_q.sclk & sclk_prev_q;

  // Wrap setting and read parameter, held until changed or reset
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wrap_q       <= '{len: mfr_pkg::RST_WRAP_LEN, dis: mfr_pkg::RST_WRAP_DIS};
      read_param_q <= mfr_pkg::RST_READ_PARAM;
    end else if (ce_i) begin
      if (wrap_set_i) begin
        wrap_q <= mfr_pkg::mfr_wrap_t'(wrap_setting_bits_i);
      end
      if (read_param_set_i) begin
        read_param_q <= read_dummy_sel_i;
      end
    end
  end

  // Shift-in values for each phase; opcode lanes follow the four-wire mode, address and mode lanes follow the command
  always_comb begin
    opc_next  = qpi_q ? {opcode_q[3:0], sync2_q.io} : {opcode_q[6:0], sync2_q.io[0]};
    addr_next = quad_q ? {addr_q[19:0], sync2_q.io} : {addr_q[21:0], sync2_q.io[1:0]};
    mode_next = quad_q ? {mode_q[3:0], sync2_q.io} : {mode_q[5:0], sync2_q.io[1:0]};
  end

  // Extra dummy clocks after the mode byte
  always_comb begin
    if (qpi_q) begin
      dummy_clks = {2'h0, read_param_q, 1'b0};
    end else if (quad_q) begin
      dummy_clks = mfr_pkg::DUMMY_CLKS_SPI_QUAD;
    end else begin
      dummy_clks = mfr_pkg::DUMMY_CLKS_DUAL;
    end
  end

  // Last clock index of the running phase
  always_comb begin
    case (state_q)
      mfr_pkg::ST_OPCODE: phase_last = (qpi_q ? mfr_pkg::OPC_CLKS_QPI : mfr_pkg::OPC_CLKS_SPI)
                                       - 5'h01;
      mfr_pkg::ST_ADDR:   phase_last = (quad_q ? mfr_pkg::ADDR_CLKS_QUAD : mfr_pkg::ADDR_CLKS_DUAL)
                                       - 5'h01;
      mfr_pkg::ST_MODE:   phase_last = (quad_q ? mfr_pkg::MODE_CLKS_QUAD : mfr_pkg::MODE_CLKS_DUAL)
                                       - 5'h01;
      mfr_pkg::ST_DUMMY:  phase_last = dummy_clks - 5'h01;
      default:            phase_last = 5'h00;
    endcase
  end

  // Command sequencer, stepped on sclk rising edges
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q   <= mfr_pkg::ST_IDLE;
      cnt_q     <= 5'h00;
      opcode_q  <= 8'h00;
      addr_q    <= 24'h000000;
      mode_q    <= 8'h00;
      quad_q    <= 1'b0;
      qpi_q     <= 1'b0;
      wrap_go_q <= 1'b0;
      reject_q  <= 1'b0;
    end else if (ce_i) begin
      if (cs_high) begin
        state_q <= mfr_pkg::ST_IDLE;
        cnt_q   <= 5'h00;
      end else if (cs_fall) begin
        cnt_q    <= 5'h00;
        qpi_q    <= four_wire_command_mode_i;
        reject_q <= 1'b0;
        if (cont_q) begin
          state_q   <= mfr_pkg::ST_ADDR;
          quad_q    <= cont_quad_q;
          wrap_go_q <= cont_quad_q & ~four_wire_command_mode_i & ~wrap_q.dis;
        end else begin
          state_q <= mfr_pkg::ST_OPCODE;
        end
      end else if (sclk_rise) begin
        case (state_q)
          mfr_pkg::ST_OPCODE: begin
            opcode_q <= opc_next;
            cnt_q    <= cnt_q + 5'h01;
            if (cnt_q == phase_last) begin
              cnt_q <= 5'h00;
              if (opc_next == mfr_pkg::OP_DUAL_IO_READ && !qpi_q) begin
                state_q <= mfr_pkg::ST_ADDR;
                quad_q  <= 1'b0;
                wrap_go_q <= 1'b0;
              end else if (opc_next == mfr_pkg::OP_QUAD_IO_READ && quad_enable_bit_i) begin
                state_q   <= mfr_pkg::ST_ADDR;
                quad_q    <= 1'b1;
                wrap_go_q <= ~qpi_q & ~wrap_q.dis;
              end else begin
                state_q  <= mfr_pkg::ST_IGNORE;
                reject_q <= 1'b1;
              end
            end
          end
          mfr_pkg::ST_ADDR: begin
            addr_q <= addr_next;
            cnt_q  <= cnt_q + 5'h01;
            if (cnt_q == phase_last) begin
              cnt_q   <= 5'h00;
              state_q <= mfr_pkg::ST_MODE;
            end
          end
          mfr_pkg::ST_MODE: begin
            mode_q <= mode_next;
            cnt_q  <= cnt_q + 5'h01;
            if (cnt_q == phase_last) begin
              cnt_q   <= 5'h00;
              state_q <= (dummy_clks == 5'h00) ? mfr_pkg::ST_DATA : mfr_pkg::ST_DUMMY;
            end
          end
          mfr_pkg::ST_DUMMY: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == phase_last) begin
              cnt_q   <= 5'h00;
              state_q <= mfr_pkg::ST_DATA;
            end
          end
          mfr_pkg::ST_DATA:   state_q <= mfr_pkg::ST_DATA;
          mfr_pkg::ST_IGNORE: state_q <= mfr_pkg::ST_IGNORE;
          default:            state_q <= mfr_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Continuous-read flag judged from mode bits 5:4 only, low nibble ignored
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cont_q      <= 1'b0;
      cont_quad_q <= 1'b0;
    end else if (ce_i) begin
      if (sclk_rise && state_q == mfr_pkg::ST_MODE && cnt_q == phase_last) begin
        cont_q      <= (mode_next[mfr_pkg::MODE_SEL_MSB:mfr_pkg::MODE_SEL_LSB]
                        == mfr_pkg::MODE_SEL_CONT);
        cont_quad_q <= quad_q;
      end else if (cs_fall && !cont_q) begin
        cont_quad_q <= 1'b0;
      end
    end
  end

  // Wrap section mask: 8, 16, 32 or 64 bytes
  assign wrap_mask = (mfr_pkg::WRAP_BASE_LEN << wrap_q.len) - 8'h01;

  // Prefetch from the array into the buffer once the address is complete
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fetch_en_q   <= 1'b0;
      pend_q       <= 1'b0;
      fetch_addr_q <= 24'h000000;
    end else if (ce_i) begin
      if (cs_high) begin
        fetch_en_q <= 1'b0;
        pend_q     <= 1'b0;
      end else begin
        if (sclk_rise && state_q == mfr_pkg::ST_ADDR && cnt_q == phase_last) begin
          fetch_en_q   <= 1'b1;
          fetch_addr_q <= addr_next;
        end
        pend_q <= mem_rd_en;
        if (pend_q) begin
          if (wrap_go_q) begin
            fetch_addr_q <= {fetch_addr_q[23:8],
                             (fetch_addr_q[7:0] & ~wrap_mask) |
                             ((fetch_addr_q[7:0] + 8'h01) & wrap_mask)};
          end else begin
            fetch_addr_q <= fetch_addr_q + 24'h000001;
          end
        end
      end
    end
  end

  // One read in flight at a time; a full buffer stalls the fetch
  assign mem_rd_en   = fetch_en_q & ~pend_q & fifo_in_ready & ~cs_high;
  assign mem_rd_addr = fetch_addr_q[MEM_AW-1:0];
  assign fifo_flush  = cs_high;

  mfr_mem #(
    .AW (MEM_AW),
    .DW (mfr_pkg::BYTE_BITS)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .ce_i       (ce_i),
    .wr_en_i    (mem_wr_en_i),
    .wr_addr_i  (mem_wr_addr_i),
    .wr_data_i  (mem_wr_data_i),
    .rd_en_i    (mem_rd_en),
    .rd_addr_i  (mem_rd_addr),
    .rd_data_o  (mem_rd_data)
  );

  mfr_fifo #(
    .WIDTH (mfr_pkg::BYTE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .flush_i     (fifo_flush),
    .in_valid_i  (pend_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem_rd_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // A new byte is taken from the buffer at its first falling edge
  assign fifo_pop = ce_i & sclk_fall & (state_q == mfr_pkg::ST_DATA) & (beat_q == 2'h0);
  assign out_byte = fifo_out_valid ? fifo_out_data : 8'hff;

  // Output shifter: drive on sclk falling edges, MSB first on the high line
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      beat_q  <= 2'h0;
      shift_q <= 8'h00;
      io_q    <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (ce_i) begin
      if (cs_high || state_q != mfr_pkg::ST_DATA) begin
        beat_q  <= 2'h0;
        io_oe_q <= 4'h0;
      end else if (sclk_fall) begin
        io_oe_q <= quad_q ? 4'hf : 4'h3;
        if (quad_q) begin
          beat_q <= (beat_q == 2'h1) ? 2'h0 : beat_q + 2'h1;
        end else begin
          beat_q <= beat_q + 2'h1;
        end
        if (beat_q == 2'h0) begin
          io_q    <= quad_q ? out_byte[7:4] : {2'h0, out_byte[7:6]};
          shift_q <= quad_q ? {out_byte[3:0], 4'h0} : {out_byte[5:0], 2'h0};
        end else begin
          io_q    <= quad_q ? shift_q[7:4] : {2'h0, shift_q[7:6]};
          shift_q <= quad_q ? {shift_q[3:0], 4'h0} : {shift_q[5:0], 2'h0};
        end
      end
    end
  end

  // Status outputs, registered
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      continuous_mode_o <= 1'b0;
      cmd_reject_o      <= 1'b0;
      busy_o            <= 1'b0;
    end else if (ce_i) begin
      continuous_mode_o <= cont_q;
      cmd_reject_o      <= reject_q;
      busy_o            <= (state_q != mfr_pkg::ST_IDLE);
    end
  end

  assign io_o    = io_q;
  assign io_oe_o = io_oe_q;

endmodule : mfr_read_front_end // mfr_read_front_end

`default_nettype wire

// File: mfr_rfe_assertions.sv
// Purpose: Port-level checks on the flash read front end
// Assumes: All link pins seen through the core clock
// Notes:   Output timing follows a two-stage pin synchroniser
`default_nettype none

module mfr_rfe_assertions (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic       cs_n_i,
  input wire logic       sclk_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  input wire logic       continuous_mode_o,
  input wire logic       cmd_reject_o,
  input wire logic       busy_o
);
  // One clock domain for all checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_lanes;
    io_oe_o inside {4'h0, 4'h3, 4'hf};
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("output enable not a dual or quad lane set");
  property p_dual_hi;
    io_oe_o == 4'h3 |-> io_o[3:2] == 2'h0;
  endproperty
  a_dual_hi: assert property (p_dual_hi)
    else $error("upper lanes active in dual output");
  property p_idle;
    cs_n_i [*5] |-> io_oe_o == 4'h0 && !busy_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("device active while deselected");
  property p_rej;
    cmd_reject_o |-> io_oe_o == 4'h0;
  endproperty
  a_rej: assert property (p_rej)
    else $error("refused command drives lines");
  property p_rej_clr;
    $fell(cs_n_i) && cmd_reject_o |-> ##[1:4] !cmd_reject_o;
  endproperty
  a_rej_clr: assert property (p_rej_clr)
    else $error("refusal flag kept into next frame");
  property p_oe_rise;
    $rose(io_oe_o[0]) |-> !$past(sclk_i, 2) && ($past(sclk_i, 3) || $past(sclk_i, 4));
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("turnaround not after a link clock fall");
  property p_oe_hold;
    |io_oe_o && !cs_n_i |=> io_oe_o == $past(io_oe_o);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output dropped while selected");
  property p_io_fall;
    |io_oe_o && $changed(io_o) |-> !$past(sclk_i, 2);
  endproperty
  a_io_fall: assert property (p_io_fall)
    else $error("data changed off a link clock fall");
  property p_cont;
    $changed(continuous_mode_o) |-> $past(busy_o);
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous flag changed outside a frame");

endmodule // mfr_rfe_assertions

bind mfr_read_front_end mfr_rfe_assertions u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
  .io_o(io_o), .io_oe_o(io_oe_o), .continuous_mode_o(continuous_mode_o),
  .cmd_reject_o(cmd_reject_o), .busy_o(busy_o));

`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the flash read front end
// Assumes: Host model drives the link at a 320 ns clock
// Notes:   Array holds a fixed pattern in its first 512 bytes
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk_i, nrst_i, ce_i, cs_n_i, sclk_i;
  logic [3:0]  io_w, io_lst, io_o, io_oe_o, h_drv, h_en;
  logic        quad_enable_bit_i, four_wire_command_mode_i;
  logic        wrap_set_i, read_param_set_i, mem_wr_en_i;
  logic [2:0]  wrap_setting_bits_i;
  logic [1:0]  read_dummy_sel_i;
  logic [11:0] mem_wr_addr_i;
  logic [7:0]  mem_wr_data_i;
  logic        continuous_mode_o, cmd_reject_o, busy_o;
  int          error_cnt, checks;

  mfr_read_front_end uut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .io_i(io_w), .io_o(io_o), .io_oe_o(io_oe_o), .quad_enable_bit_i(quad_enable_bit_i),
    .four_wire_command_mode_i(four_wire_command_mode_i), .wrap_set_i(wrap_set_i),
    .wrap_setting_bits_i(wrap_setting_bits_i), .read_param_set_i(read_param_set_i),
    .read_dummy_sel_i(read_dummy_sel_i), .mem_wr_en_i(mem_wr_en_i),
    .mem_wr_addr_i(mem_wr_addr_i), .mem_wr_data_i(mem_wr_data_i),
    .continuous_mode_o(continuous_mode_o), .cmd_reject_o(cmd_reject_o), .busy_o(busy_o));
  mfr_host_model u_h (.core_clk_i(core_clk_i), .io_i(io_w), .cs_n_o(cs_n_i),
                      .sclk_o(sclk_i), .drv_o(h_drv), .en_o(h_en));

  // Core clock
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // Wire level; a released line shows a toggling pattern
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      io_w[j] = io_oe_o[j] ? io_o[j] : (h_en[j] ? h_drv[j] : (io_lst[j] !== 1'b1));
    end
  end
  always_ff @(posedge core_clk_i) io_lst <= io_w;

  // Array pattern
  function automatic logic [7:0] dat(input logic [11:0] x);
    return 8'(x * 5) ^ x[11:4];
  endfunction

  // Compare and count
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Load wrap bits and read parameter with one strobe
  task automatic cfg(input logic [2:0] w, input logic [1:0] p);
    @(posedge core_clk_i);
    #2;
    wrap_setting_bits_i = w;
    read_dummy_sel_i    = p;
    wrap_set_i          = 1'b1;
    read_param_set_i    = 1'b1;
    @(posedge core_clk_i);
    #2;
    wrap_set_i          = 1'b0;
    read_param_set_i    = 1'b0;
  endtask

  // One read frame; opcode 00 means opcode skipped
  task automatic rd(input logic [7:0] op, input bit qp, input int w, dm, n, wl,
                    input logic [23:0] a, input logic [7:0] m);
    logic [7:0]  b;
    logic [23:0] e;
    logic [3:0]  q;
    u_h.sel(1'b0);
    if (op != 8'h00) u_h.shift({16'h0, op}, 8, qp ? 4 : 1, 1'b0);
    u_h.shift(a, 24, w, 1'b0);
    u_h.shift({16'h0, m}, 8, w, 1'b1);
    repeat (dm) u_h.clk1(4'h0, 4'h0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      u_h.rxb(w, b);
      e = a + 24'(i);
      if (wl != 0) e = (a & 24'(~(wl - 1))) | (e & 24'(wl - 1));
      chk(b, dat(e[11:0]));
    end
    u_h.sel(1'b1);
  endtask

  // Print verdict and stop
  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge core_clk_i);
    error_cnt++;
    end_sim();
  end

  // Test sequence
  initial begin
    nrst_i                   = 1'b0;
    ce_i                     = 1'b1;
    quad_enable_bit_i        = 1'b1;
    four_wire_command_mode_i = 1'b0;
    wrap_set_i               = 1'b0;
    read_param_set_i         = 1'b0;
    wrap_setting_bits_i      = 3'h1;
    read_dummy_sel_i         = 2'h0;
    mem_wr_en_i              = 1'b0;
    mem_wr_addr_i            = 12'h000;
    mem_wr_data_i            = 8'h00;
    repeat (16) @(posedge core_clk_i);
    #2;
    nrst_i = 1'b1;
    for (int x = 0; x < 512; x++) begin
      mem_wr_en_i   = 1'b1;
      mem_wr_addr_i = 12'(x);
      mem_wr_data_i = dat(12'(x));
      @(posedge core_clk_i);
      #2;
    end
    mem_wr_en_i = 1'b0;
    rd(8'hbb, 0, 2, 0, 3, 0, 24'h0f3, 8'h25);
    chk(8'(continuous_mode_o), 8'h01);
    rd(8'h00, 0, 2, 0, 2, 0, 24'h1fe, 8'h1f);
    chk(8'(continuous_mode_o), 8'h00);
    rd(8'hbb, 0, 2, 0, 1, 0, 24'h010, 8'h2f);
    chk(8'(continuous_mode_o), 8'h01);
    rd(8'h00, 0, 2, 0, 0, 0, 24'hffffff, 8'hff);
    chk(8'(continuous_mode_o), 8'h00);
    rd(8'heb, 0, 4, 4, 4, 0, 24'h106, 8'h00);
    for (int l = 0; l < 4; l++) begin
      cfg({2'(l), 1'b0}, 2'h0);
      rd(8'heb, 0, 4, 4, 4, 8 << l, 24'h0fe + 24'(8 << l), l == 3 ? 8'h25 : 8'h00);
    end
    chk(8'(continuous_mode_o), 8'h01);
    rd(8'h00, 0, 4, 4, 2, 64, 24'h020, 8'h25);
    rd(8'h00, 0, 4, 0, 0, 0, 24'hffffff, 8'hff);
    chk(8'(continuous_mode_o), 8'h00);
    quad_enable_bit_i = 1'b0;
    rd(8'heb, 0, 4, 0, 0, 0, 24'h000, 8'h00);
    chk(8'(cmd_reject_o), 8'h01);
    quad_enable_bit_i        = 1'b1;
    four_wire_command_mode_i = 1'b1;
    rd(8'hbb, 1, 4, 0, 0, 0, 24'h000, 8'h00);
    chk(8'(cmd_reject_o), 8'h01);
    for (int p = 0; p < 4; p++) begin
      if (p > 0) cfg(3'b110, 2'(p));
      rd(8'heb, 1, 4, 2 * p, 2, 0, 24'h13f, p == 3 ? 8'h25 : 8'h00);
    end
    chk(8'(cmd_reject_o), 8'h00);
    rd(8'h00, 1, 4, 6, 2, 0, 24'h1f0, 8'h00);
    end_sim();
  end

endmodule // tb_top

`default_nettype wire
